// ===== design/ars_pkg.sv
// package: register map, field layout and reset values of the reference select bank
package ars_pkg;

  // special-function register pages and addresses
  localparam logic [3:0] ARS_PAGE_REF     = 4'h0;
  localparam logic [3:0] ARS_PAGE_OFFSET  = 4'hF;
  localparam logic [7:0] ARS_ADDR_REFCTL  = 8'hD1;
  localparam logic [7:0] ARS_ADDR_OFF_HI  = 8'h8E;
  localparam logic [7:0] ARS_ADDR_OFF_LO  = 8'h8D;

  // reference_control field positions
  localparam int ARS_GND_BIT    = 5;
  localparam int ARS_REFSEL_MSB = 4;
  localparam int ARS_REFSEL_LSB = 3;
  localparam int ARS_SENSE_BIT  = 2;

  // reference_control reset value and writable mask
  localparam logic [7:0] ARS_REFCTL_RESET = 8'h18;
  localparam logic [7:0] ARS_REFCTL_MASK  = 8'h3C;

  // production offset default; arbitrary, actual part contents are strapped in
  localparam logic [9:0] ARS_OFFSET_DEFAULT = 10'h000;

  // converter reference sources
  typedef enum logic [1:0] {
    ARS_REF_EXT_PIN = 2'h0,
    ARS_REF_SUPPLY  = 2'h1,
    ARS_REF_DIG_REG = 2'h2,
    ARS_REF_HS_INT  = 2'h3
  } ars_ref_type;

  // converter ground sources
  typedef enum logic {
    ARS_GND_CHIP   = 1'b0,
    ARS_GND_ANALOG = 1'b1
  } ars_gnd_type;

  // converter phases
  typedef enum logic [2:0] {
    ARS_PH_IDLE   = 3'b001,
    ARS_PH_SAMPLE = 3'b010,
    ARS_PH_CONV   = 3'b100
  } ars_phase_type;

endpackage : ars_pkg

// ===== design/ars_ground_mux.sv
// ground select decision for the converter, per phase
`timescale 1ns/100ps
`default_nettype none
module ars_ground_mux
  import ars_pkg::*;
(
  // settings
  input  wire logic        ground_select,
  input  wire logic [1:0]  reference_select,
  // converter status
  input  wire logic        sample_phase,
  input  wire logic        conv_phase,
  input  wire logic        sensor_is_input,
  // decision
  output logic             gnd_analog
);

  always_comb begin
    gnd_analog = ground_select; // RQ5
    if (sample_phase && sensor_is_input) begin
      gnd_analog = ARS_GND_CHIP; // RQ6
    end
    if (conv_phase && (reference_select == ARS_REF_HS_INT)) begin
      gnd_analog = ARS_GND_CHIP; // RQ7
    end
  end

endmodule : ars_ground_mux
`default_nettype wire

// ===== design/ars_regs.sv
// reference select and temperature offset register bank
//
// Functional notes
// [RQ1] reference_select bits 4:3 pick external pin, supply, regulator or fast reference.
// [RQ2] ground_select bit 5 picks device ground at 0 and the analog ground pin at 1.
// [RQ3] sensor_enable bit 2 turns the temperature sensor on at 1 and off at 0.
// [RQ4] with select 11 the fast internal reference powers up only while the converter needs it.
// [RQ5] analog ground selected applies to both sampling and conversion.
// [RQ6] sampling the temperature sensor always uses chip ground.
// [RQ7] converting with the fast internal reference always uses chip ground.
// [RQ8] the 10-bit offset reads as bits 9:2 in the high register and 1:0 in low bits 7:6.
// [RQ9] low offset bits 5:0 read zero and ignore writes.
// [RQ10] control bits 7:6 and 1:0 read zero and ignore writes.
// [RQ11] the control register decodes on page 0x0 address 0xD1.
// [RQ12] the offset registers decode on page 0xF at 0x8E high and 0x8D low.
// [RQ13] the offset holds the production sensor result taken with the fast internal reference.
// [RQ14] the control bits drive their analog outputs and hold until write or reset.
`timescale 1ns/100ps
`default_nettype none
module ars_regs
  import ars_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // special-function register bus
  input  wire logic [3:0]  sfr_page,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_hit,
  // production offset value from trim storage
  input  wire logic [9:0]  trim_offset,
  // converter status
  input  wire logic        conv_need_ref,
  input  wire logic        conv_sampling,
  input  wire logic        conv_converting,
  input  wire logic        conv_sensor_input,
  // analog controls
  output logic      [1:0]  reference_select,
  output logic             ground_select,
  output logic             sensor_enable,
  output logic             hs_ref_power,
  output logic             gnd_analog
);

  ////////////////////////////////////////////////////////////////////////////
  // decode

  function automatic logic hit(input logic [3:0] pg, input logic [7:0] ad,
                               input logic [3:0] wp, input logic [7:0] wa);
    hit = (pg == wp) && (ad == wa);
  endfunction : hit

  // one select per register; page and address never match two at once
  logic       sel_ctl;
  logic       sel_hi;
  logic       sel_lo;
  logic       wr_ctl;
  logic [2:0] rd_sel;
  logic [1:0] ref_sel;

  assign sel_ctl = hit(sfr_page, sfr_addr, ARS_PAGE_REF, ARS_ADDR_REFCTL); // RQ11
  assign sel_hi  = hit(sfr_page, sfr_addr, ARS_PAGE_OFFSET, ARS_ADDR_OFF_HI); // RQ12
  assign sel_lo  = hit(sfr_page, sfr_addr, ARS_PAGE_OFFSET, ARS_ADDR_OFF_LO); // RQ12
  assign wr_ctl  = sfr_wr && sel_ctl;
  assign rd_sel  = sfr_rd ? {sel_ctl, sel_hi, sel_lo} : 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // control register

  logic [7:0] refctl_r;
  logic [7:0] refctl_nxt;

  // unused bits masked on the way in, so they can never be set or read back
  always_comb begin
    refctl_nxt = refctl_r;
    if (wr_ctl) begin
      refctl_nxt = sfr_wdata & ARS_REFCTL_MASK; // RQ10 RQ14
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      refctl_r <= ARS_REFCTL_RESET;
    end else begin
      refctl_r <= refctl_nxt;
    end
  end

  assign ref_sel = refctl_r[ARS_REFSEL_MSB:ARS_REFSEL_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // production offset

  logic [9:0] offset_r;
  logic [9:0] offset_nxt;
  logic       offset_loaded_r;
  logic       offset_loaded_nxt;

  // trim captured once after reset release; a reset flop may not take a port value
  always_comb begin
    offset_nxt        = offset_r;
    offset_loaded_nxt = 1'b1;
    if (!offset_loaded_r) begin
      offset_nxt = trim_offset; // RQ13
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      offset_r        <= ARS_OFFSET_DEFAULT;
      offset_loaded_r <= 1'b0;
    end else begin
      offset_r        <= offset_nxt;
      offset_loaded_r <= offset_loaded_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       hit_r;
  logic       hit_nxt;

  // data drops back to zero between reads, so a stale byte never shows
  always_comb begin
    rdata_nxt = 8'h00;
    hit_nxt   = 1'b0;
    case (rd_sel)
      3'b100: begin
        rdata_nxt = refctl_r & ARS_REFCTL_MASK; // RQ10
        hit_nxt   = 1'b1;
      end
      3'b010: begin
        rdata_nxt = offset_r[9:2]; // RQ8
        hit_nxt   = 1'b1;
      end
      3'b001: begin
        rdata_nxt = {offset_r[1:0], 6'h00}; // RQ8 RQ9
        hit_nxt   = 1'b1;
      end
      default: begin
        rdata_nxt = 8'h00;
        hit_nxt   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 8'h00;
      hit_r   <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      hit_r   <= hit_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fast reference power

  logic       hs_pwr_r;
  logic       hs_pwr_nxt;

  // powered only when selected and the converter asks; registered, so it
  // trails the request by one cycle and the converter must allow for that
  always_comb begin
    hs_pwr_nxt = (ref_sel == ARS_REF_HS_INT) && conv_need_ref; // RQ4
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hs_pwr_r <= 1'b0;
    end else begin
      hs_pwr_r <= hs_pwr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ground reference

  logic       gnd_r;
  logic       gnd_nxt;
  logic       gnd_comb;

  // both overrides sit in the mux, so the phase rules are decided in one place
  ars_ground_mux u_gnd (
    .ground_select    (refctl_r[ARS_GND_BIT]),
    .reference_select (ref_sel),
    .sample_phase     (conv_sampling),
    .conv_phase       (conv_converting),
    .sensor_is_input  (conv_sensor_input),
    .gnd_analog       (gnd_comb)
  );

  always_comb begin
    gnd_nxt = gnd_comb; // RQ5 RQ6 RQ7
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gnd_r <= 1'b0;
    end else begin
      gnd_r <= gnd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // every pin comes from a flop, so no decode glitch reaches the analog side
  assign reference_select = ref_sel; // RQ1
  assign ground_select    = refctl_r[ARS_GND_BIT]; // RQ2
  assign sensor_enable    = refctl_r[ARS_SENSE_BIT]; // RQ3
  assign hs_ref_power     = hs_pwr_r;
  assign gnd_analog       = gnd_r;
  assign sfr_rdata        = rdata_r;
  assign sfr_hit          = hit_r;

endmodule : ars_regs
`default_nettype wire

// ===== testbench/ars_regs_properties.sv
// checker: port-level properties of the reference select bank
`timescale 1ns/100ps
`default_nettype none
module ars_regs_properties
  import ars_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       arst_n,
  // register bus
  input wire logic [3:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_hit,
  // production offset
  input wire logic [9:0] trim_offset,
  // converter status
  input wire logic       conv_need_ref,
  input wire logic       conv_sampling,
  input wire logic       conv_converting,
  input wire logic       conv_sensor_input,
  // analog controls
  input wire logic [1:0] reference_select,
  input wire logic       ground_select,
  input wire logic       sensor_enable,
  input wire logic       hs_ref_power,
  input wire logic       gnd_analog
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic ctl;
  logic offl;
  logic fast;
  assign ctl  = sfr_page == ARS_PAGE_REF && sfr_addr == ARS_ADDR_REFCTL;
  assign offl = sfr_page == ARS_PAGE_OFFSET && sfr_addr == ARS_ADDR_OFF_LO;
  assign fast = reference_select == 2'h3;
  // the release edge itself still resets the flop, so it is left out
  hs_on_a: assert property (arst_n && fast && conv_need_ref |=> hs_ref_power)
    else $error("fast reference not powered");
  hs_off_a: assert property (!(fast && conv_need_ref) |=> !hs_ref_power)
    else $error("fast reference powered needlessly");
  gnd_conv_a: assert property (conv_converting && fast |=> !gnd_analog)
    else $error("conversion ground not chip");
  gnd_samp_a: assert property (conv_sampling && conv_sensor_input |=> !gnd_analog)
    else $error("sensor sampling ground not chip");
  gnd_sel_a: assert property (!(conv_sampling && conv_sensor_input)
    && !(conv_converting && fast) |=> gnd_analog == $past(ground_select))
    else $error("ground does not follow select");
  ctl_hold_a: assert property (!sfr_wr
    |=> $stable({reference_select, ground_select, sensor_enable}))
    else $error("controls moved without write");
  ctl_wr_a: assert property (sfr_wr && ctl
    |=> {ground_select, reference_select, sensor_enable} == $past(sfr_wdata[5:2]))
    else $error("control write lost");
  ctl_rd_a: assert property (sfr_rd && ctl |=> sfr_hit
    && sfr_rdata == {2'h0, $past({ground_select, reference_select, sensor_enable}), 2'h0})
    else $error("control read wrong");
  lo_rd_a: assert property (sfr_rd && offl |=> sfr_hit && sfr_rdata[5:0] == 6'h00)
    else $error("low offset unused bits set");
  idle_rd_a: assert property (!sfr_rd |=> sfr_rdata == 8'h00 && !sfr_hit)
    else $error("read data without read");
  cover property (sfr_wr && ctl);
  cover property (conv_sampling && conv_sensor_input && ground_select);
  cover property (hs_ref_power);
endmodule : ars_regs_properties
bind ars_regs ars_regs_properties i_ars_regs_properties (
  .clk               (clk),
  .arst_n            (arst_n),
  .sfr_page          (sfr_page),
  .sfr_addr          (sfr_addr),
  .sfr_wr            (sfr_wr),
  .sfr_rd            (sfr_rd),
  .sfr_wdata         (sfr_wdata),
  .sfr_rdata         (sfr_rdata),
  .sfr_hit           (sfr_hit),
  .trim_offset       (trim_offset),
  .conv_need_ref     (conv_need_ref),
  .conv_sampling     (conv_sampling),
  .conv_converting   (conv_converting),
  .conv_sensor_input (conv_sensor_input),
  .reference_select  (reference_select),
  .ground_select     (ground_select),
  .sensor_enable     (sensor_enable),
  .hs_ref_power      (hs_ref_power),
  .gnd_analog        (gnd_analog)
);
`default_nettype wire

// ===== testbench/test_ars_regs.sv
// testbench: register access and ground/reference control of the reference bank
`timescale 1ns/100ps
`default_nettype none
module test_ars_regs
  import ars_pkg::*;
();
  logic       clk, arst_n, sfr_wr, sfr_rd, sfr_hit, conv_need_ref, conv_sampling;
  logic       conv_converting, conv_sensor_input, ground_select, sensor_enable;
  logic       hs_ref_power, gnd_analog;
  logic [1:0] reference_select;
  logic [3:0] sfr_page;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [9:0] trim_offset;
  int         error_cnt = 0;
  int         checks = 0;
  ars_regs i_ars_regs (
    .clk               (clk),
    .arst_n            (arst_n),
    .sfr_page          (sfr_page),
    .sfr_addr          (sfr_addr),
    .sfr_wr            (sfr_wr),
    .sfr_rd            (sfr_rd),
    .sfr_wdata         (sfr_wdata),
    .sfr_rdata         (sfr_rdata),
    .sfr_hit           (sfr_hit),
    .trim_offset       (trim_offset),
    .conv_need_ref     (conv_need_ref),
    .conv_sampling     (conv_sampling),
    .conv_converting   (conv_converting),
    .conv_sensor_input (conv_sensor_input),
    .reference_select  (reference_select),
    .ground_select     (ground_select),
    .sensor_enable     (sensor_enable),
    .hs_ref_power      (hs_ref_power),
    .gnd_analog        (gnd_analog)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [3:0] p, input logic [7:0] a, d);
    @(posedge clk);
    sfr_wr    <= w;
    sfr_rd    <= !w;
    sfr_page  <= p;
    sfr_addr  <= a;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    #1;
  endtask : acc
  task automatic cv(input logic [3:0] c, input logic [1:0] exp);
    @(posedge clk);
    {conv_need_ref, conv_sampling, conv_converting, conv_sensor_input} <= c;
    @(posedge clk);
    #1;
    chk({6'h00, hs_ref_power, gnd_analog}, {6'h00, exp});
  endtask : cv
  task automatic results();
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    acc(0, ARS_PAGE_REF, ARS_ADDR_REFCTL, 8'h00);
    chk(sfr_rdata, 8'h18);
    acc(1, ARS_PAGE_REF, ARS_ADDR_REFCTL, 8'hFF);
    acc(0, ARS_PAGE_REF, ARS_ADDR_REFCTL, 8'h00);
    chk(sfr_rdata, 8'h3C);
    chk({2'h0, ground_select, reference_select, sensor_enable, 2'h0}, 8'h3C);
    for (int i = 0; i < 4; i++) begin
      acc(1, ARS_PAGE_REF, ARS_ADDR_REFCTL, 8'(i << 3));
      chk({6'h00, reference_select}, 8'(i));
    end
    acc(0, 4'h1, ARS_ADDR_REFCTL, 8'h00);
    chk(sfr_rdata, 8'h00);
    chk({7'h00, sfr_hit}, 8'h00);
  endtask : t_regs
  task automatic t_offset();
    acc(1, ARS_PAGE_OFFSET, ARS_ADDR_OFF_LO, 8'hFF);
    acc(0, ARS_PAGE_OFFSET, ARS_ADDR_OFF_HI, 8'h00);
    chk(sfr_rdata, 8'hA9);
    chk({7'h00, sfr_hit}, 8'h01);
    acc(0, ARS_PAGE_OFFSET, ARS_ADDR_OFF_LO, 8'h00);
    chk(sfr_rdata, 8'h40);
  endtask : t_offset
  task automatic t_conv();
    acc(1, ARS_PAGE_REF, ARS_ADDR_REFCTL, 8'h38);
    cv(4'b1000, 2'b11);
    cv(4'b0101, 2'b00);
    cv(4'b0010, 2'b00);
    cv(4'b0100, 2'b01);
    acc(1, ARS_PAGE_REF, ARS_ADDR_REFCTL, 8'h28);
    cv(4'b1010, 2'b01);
  endtask : t_conv
  // mid-run reset: controls return to reset values, trim is taken again
  task automatic t_reset();
    acc(1, ARS_PAGE_REF, ARS_ADDR_REFCTL, 8'h24);
    chk({2'h0, ground_select, reference_select, sensor_enable, 2'h0}, 8'h24);
    @(posedge clk);
    {conv_need_ref, conv_sampling, conv_converting, conv_sensor_input} <= 4'h0;
    arst_n      <= 1'b0;
    trim_offset <= 10'h15B;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({2'h0, ground_select, reference_select, sensor_enable, 2'h0}, 8'h18);
    acc(0, ARS_PAGE_OFFSET, ARS_ADDR_OFF_HI, 8'h00);
    chk(sfr_rdata, 8'h56);
  endtask : t_reset
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {arst_n, sfr_wr, sfr_rd, sfr_page, sfr_addr, sfr_wdata} = '0;
    {conv_need_ref, conv_sampling, conv_converting, conv_sensor_input} = 4'h0;
    trim_offset = 10'h2A5;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs();
    t_offset();
    t_conv();
    t_reset();
    results();
  end
  // whole run is well under a microsecond
  initial begin
    #10000;
    error_cnt++;
    results();
  end
endmodule : test_ars_regs
`default_nettype wire
